/* design/qrs_params.svh */
`ifndef QRS_PARAMS_SVH
`define QRS_PARAMS_SVH

// ************************************************************
// Clock and timing figures (times in ns)
// ************************************************************
`define QRS_CLK_NS          50
`define QRS_EVAL_NS         48000000
`define QRS_LEB_NS          250
`define QRS_ONMAX_NS        25000
`define QRS_OFFMAX_NS       45000
`define QRS_RING_LONG_NS    20000
`define QRS_RING_SHORT_NS   2500
`define QRS_OVP_BLANK_NS    1000
`define QRS_SW_BLANK_NS     200

// Least times round up, longest times round down
`define QRS_EVAL_CYC        (`QRS_EVAL_NS / `QRS_CLK_NS)
`define QRS_LEB_CYC         ((`QRS_LEB_NS + `QRS_CLK_NS - 1) / `QRS_CLK_NS)
`define QRS_ONMAX_CYC       (`QRS_ONMAX_NS / `QRS_CLK_NS)
`define QRS_OFFMAX_CYC      (`QRS_OFFMAX_NS / `QRS_CLK_NS)
`define QRS_RING_LONG_CYC   ((`QRS_RING_LONG_NS + `QRS_CLK_NS - 1) / `QRS_CLK_NS)
`define QRS_RING_SHORT_CYC  ((`QRS_RING_SHORT_NS + `QRS_CLK_NS - 1) / `QRS_CLK_NS)
`define QRS_OVP_BLANK_CYC   ((`QRS_OVP_BLANK_NS + `QRS_CLK_NS - 1) / `QRS_CLK_NS)
`define QRS_SW_BLANK_CYC    ((`QRS_SW_BLANK_NS + `QRS_CLK_NS - 1) / `QRS_CLK_NS)

// ************************************************************
// Widths, limits and reset values
// ************************************************************
`define QRS_EVAL_W          20
`define QRS_TMR_W           16
`define QRS_OFS_W           8
`define QRS_CODE_W          4
`define QRS_SYNC_W          10
`define QRS_VSEL_MIN        3'h1
`define QRS_VSEL_MAX        3'h7
`define QRS_VCNT_MIN        3'h0
`define QRS_VCNT_MAX        3'h7

`endif

/* design/qrs_pkg.sv */
`include "qrs_params.svh"

package qrs_pkg;

    // ************************************************************
    // Switching phases
    // ************************************************************
    typedef enum logic [1:0] {
        QRS_ON,
        QRS_RING,
        QRS_WAIT,
        QRS_LATCH
    } qrs_phase_t;

    // ************************************************************
    // Whole state of the timing core
    // ************************************************************
    typedef struct packed {
        qrs_phase_t                 phase;
        logic                       gate;
        logic                       latched;
        logic [2:0]                 vsel;
        logic [2:0]                 vcnt;
        logic                       seen_low;
        logic                       seen_high;
        logic [`QRS_EVAL_W-1:0]     eval_cnt;
        logic [`QRS_TMR_W-1:0]      phase_cnt;
        logic [`QRS_TMR_W-1:0]      ring_cnt;
        logic [`QRS_TMR_W-1:0]      ovp_cnt;
        logic [`QRS_TMR_W-1:0]      sw_cnt;
        logic                       zc_prev;
        logic                       thr_sel;
        logic [`QRS_OFS_W-1:0]      offset;
    } qrs_state_t;

endpackage

/* design/qrs_sync.sv */
`timescale 1ns/10ps

// ************************************************************
// Two-stage synchroniser for comparator levels
// ************************************************************
module qrs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule

/* design/qrs_core.sv */
`timescale 1ns/10ps
`include "qrs_params.svh"

// Contract
// - Every 48ms period, step the valley select from the thresholds seen.
// - Never above low: up; above low only: hold; above high: down.
// - Valley select stays 1..7; steps past the ends are ignored.
// - Feedback above reset threshold forces valley select to 1.
// - Start-up sets valley select to 1.
// - Low/high thresholds are selected from the sensed line level.
// - Valley counter saturates at 0 and 7.
// - Each falling 100mV crossing after turn-off adds one to the valley counter.
// - Valley counter clears whenever the gate goes high.
// - Overvoltage while off, beyond a blanking time, latches off.
// - Ringing suppression is long below its threshold, short above.
// - Gate stays low for the whole ringing suppression time.
// - After suppression, turn on once valley count reaches valley select.
// - After the maximum off-time, turn on regardless.
// - Current sense above feedback turns the switch off.
// - Feedback and limit current comparators are ignored during leading-edge blanking; the short-winding comparator is not.
// - Gate high beyond maximum on-time turns off.
// - Current limit trip turns off in that cycle, after blanking.
// - Short-winding trip is spike-filtered before latching off.
// - Excess sense-pin current lowers the current limit via a nonlinear table.
module qrs_core #(
    parameter int EVAL_CYCLES = `QRS_EVAL_CYC
) (
    input  wire logic                   clk_i,
    input  wire logic                   reset_n_i,
    input  wire logic                   fb_above_low_i,
    input  wire logic                   fb_above_high_i,
    input  wire logic                   fb_above_reset_i,
    input  wire logic                   line_high_i,
    input  wire logic                   zc_above_100mv_i,
    input  wire logic                   zc_above_ovp_i,
    input  wire logic                   zc_above_ringsel_i,
    input  wire logic                   cs_above_fb_i,
    input  wire logic                   cs_above_limit_i,
    input  wire logic                   cs_above_short_i,
    input  wire logic                   foldback_over_i,
    input  wire logic [`QRS_CODE_W-1:0] foldback_code_i,
    output logic                        gate_output_a_o,
    output logic                        latch_off_o,
    output logic                        thr_line_high_o,
    output logic [2:0]                  valley_select_o,
    output logic [2:0]                  valley_count_o,
    output logic [`QRS_OFS_W-1:0]       limit_offset_o,
    output qrs_pkg::qrs_phase_t         phase_o
);
    import qrs_pkg::*;

    // ************************************************************
    // Timing constants at register width
    // ************************************************************
    localparam logic [`QRS_EVAL_W-1:0] EVAL_LAST  = `QRS_EVAL_W'(EVAL_CYCLES - 1);
    localparam logic [`QRS_TMR_W-1:0]  LEB_CYC    = `QRS_TMR_W'(`QRS_LEB_CYC);
    localparam logic [`QRS_TMR_W-1:0]  ONMAX_LAST = `QRS_TMR_W'(`QRS_ONMAX_CYC - 1);
    localparam logic [`QRS_TMR_W-1:0]  OFFMAX_LST = `QRS_TMR_W'(`QRS_OFFMAX_CYC - 1);
    localparam logic [`QRS_TMR_W-1:0]  RING_LONG  = `QRS_TMR_W'(`QRS_RING_LONG_CYC);
    localparam logic [`QRS_TMR_W-1:0]  RING_SHORT = `QRS_TMR_W'(`QRS_RING_SHORT_CYC);
    localparam logic [`QRS_TMR_W-1:0]  OVP_LAST   = `QRS_TMR_W'(`QRS_OVP_BLANK_CYC - 1);
    localparam logic [`QRS_TMR_W-1:0]  SW_LAST    = `QRS_TMR_W'(`QRS_SW_BLANK_CYC - 1);
    localparam logic [`QRS_TMR_W-1:0]  TMR_ONE    = `QRS_TMR_W'(1);
    localparam logic [`QRS_TMR_W-1:0]  TMR_FULL   = '1;

    // ************************************************************
    // Comparator inputs into the clock domain
    // ************************************************************
    logic [`QRS_SYNC_W-1:0] cmp_s;
    logic fb_low_s, fb_high_s, fb_reset_s, line_s, zc_s;
    logic ovp_s, ringsel_s, cs_fb_s, cs_lim_s, cs_short_s, fold_s;

    qrs_sync #(
        .WIDTH (`QRS_SYNC_W + 1)
    ) u_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .async_i   ({foldback_over_i, cs_above_short_i, cs_above_limit_i, cs_above_fb_i,
                     zc_above_ringsel_i, zc_above_ovp_i, zc_above_100mv_i, line_high_i,
                     fb_above_reset_i, fb_above_high_i, fb_above_low_i}),
        .sync_o    ({fold_s, cmp_s})
    );

    // Unpack synchronised comparator levels
    assign {cs_short_s, cs_lim_s, cs_fb_s, ringsel_s, ovp_s, zc_s,
            line_s, fb_reset_s, fb_high_s, fb_low_s} = cmp_s;

    // ************************************************************
    // Foldback curve: grows faster than the excess current
    // ************************************************************
    function automatic logic [`QRS_OFS_W-1:0] fold_lut(input logic [`QRS_CODE_W-1:0] code);
        logic [`QRS_OFS_W-1:0] v;
        v = '0;
        unique case (code)
            4'h0: v = 8'h00;
            4'h1: v = 8'h01;
            4'h2: v = 8'h03;
            4'h3: v = 8'h06;
            4'h4: v = 8'h0A;
            4'h5: v = 8'h0F;
            4'h6: v = 8'h15;
            4'h7: v = 8'h1C;
            4'h8: v = 8'h24;
            4'h9: v = 8'h2D;
            4'hA: v = 8'h37;
            4'hB: v = 8'h42;
            4'hC: v = 8'h4E;
            4'hD: v = 8'h5B;
            4'hE: v = 8'h69;
            4'hF: v = 8'h78;
        endcase
        return v;
    endfunction

    // ************************************************************
    // Next-state logic
    // ************************************************************
    qrs_state_t st_r, st_nxt;
    logic       blank;
    logic       off_req;
    logic       zc_fall;
    logic       eval_end;

    assign blank    = (st_r.phase_cnt < LEB_CYC);
    assign zc_fall  = st_r.zc_prev && !zc_s;
    assign eval_end = (st_r.eval_cnt == EVAL_LAST);
    // Limit trips in the same cycle as the comparator path once unblanked
    assign off_req  = (!blank && (cs_fb_s || cs_lim_s)) ||
                      (st_r.phase_cnt >= ONMAX_LAST);

    always_comb begin
        st_nxt         = st_r;
        st_nxt.zc_prev = zc_s;
        st_nxt.thr_sel = line_s;

        // Valley select: flags gather one period, then one step
        if (eval_end) begin
            st_nxt.eval_cnt  = '0;
            st_nxt.seen_low  = 1'b0;
            st_nxt.seen_high = 1'b0;
            if (st_r.seen_high || fb_high_s) begin
                if (st_r.vsel != `QRS_VSEL_MIN) begin
                    st_nxt.vsel = st_r.vsel - 3'h1;
                end
            end else if (!(st_r.seen_low || fb_low_s)) begin
                if (st_r.vsel != `QRS_VSEL_MAX) begin
                    st_nxt.vsel = st_r.vsel + 3'h1;
                end
            end
        end else begin
            st_nxt.eval_cnt  = st_r.eval_cnt + `QRS_EVAL_W'(1);
            st_nxt.seen_low  = st_r.seen_low || fb_low_s;
            st_nxt.seen_high = st_r.seen_high || fb_high_s;
        end
        // Sudden load step: do not wait for the period to end
        if (fb_reset_s) begin
            st_nxt.vsel = `QRS_VSEL_MIN;
        end

        // Off-phase bookkeeping shared by ring and wait
        if (st_r.phase == QRS_RING || st_r.phase == QRS_WAIT) begin
            if (st_r.phase_cnt != TMR_FULL) begin
                st_nxt.phase_cnt = st_r.phase_cnt + TMR_ONE;
            end
            if (zc_fall && st_r.vcnt != `QRS_VCNT_MAX) begin
                st_nxt.vcnt = st_r.vcnt + 3'h1;
            end
            st_nxt.ovp_cnt = ovp_s ? st_r.ovp_cnt + TMR_ONE : '0;
        end

        unique case (st_r.phase)
            QRS_ON: begin
                st_nxt.phase_cnt = st_r.phase_cnt + TMR_ONE;
                st_nxt.sw_cnt    = cs_short_s ? st_r.sw_cnt + TMR_ONE : '0;
                if (fold_s) begin
                    st_nxt.offset = fold_lut(foldback_code_i);
                end
                if (cs_short_s && st_r.sw_cnt >= SW_LAST) begin
                    st_nxt.phase   = QRS_LATCH;
                    st_nxt.gate    = 1'b0;
                    st_nxt.latched = 1'b1;
                end else if (off_req) begin
                    st_nxt.phase     = QRS_RING;
                    st_nxt.gate      = 1'b0;
                    st_nxt.phase_cnt = '0;
                    st_nxt.ovp_cnt   = '0;
                    st_nxt.ring_cnt  = ringsel_s ? RING_SHORT : RING_LONG;
                end
            end
            QRS_RING: begin
                // Gate held low while ringing dies down
                st_nxt.ring_cnt = st_r.ring_cnt - TMR_ONE;
                if (st_r.ring_cnt <= TMR_ONE) begin
                    st_nxt.phase = QRS_WAIT;
                end
            end
            QRS_WAIT: begin
                if (st_r.vcnt >= st_r.vsel ||
                    st_r.phase_cnt >= OFFMAX_LST) begin
                    st_nxt.phase     = QRS_ON;
                    st_nxt.gate      = 1'b1;
                    st_nxt.vcnt      = `QRS_VCNT_MIN;
                    st_nxt.phase_cnt = '0;
                    st_nxt.sw_cnt    = '0;
                end
            end
            QRS_LATCH: begin
                st_nxt.gate = 1'b0;
            end
        endcase

        // Overvoltage wins over a turn-on in the same cycle
        if ((st_r.phase == QRS_RING || st_r.phase == QRS_WAIT) &&
            ovp_s && st_r.ovp_cnt >= OVP_LAST) begin
            st_nxt.phase   = QRS_LATCH;
            st_nxt.gate    = 1'b0;
            st_nxt.latched = 1'b1;
        end
    end

    // ************************************************************
    // State register; start-up waits out a long suppression
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st_r           <= '0;
            st_r.phase     <= QRS_RING;
            st_r.ring_cnt  <= RING_LONG;
            st_r.vsel      <= `QRS_VSEL_MIN;
            st_r.vcnt      <= `QRS_VCNT_MIN;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flops
    assign gate_output_a_o = st_r.gate;
    assign latch_off_o     = st_r.latched;
    assign thr_line_high_o = st_r.thr_sel;
    assign valley_select_o = st_r.vsel;
    assign valley_count_o  = st_r.vcnt;
    assign limit_offset_o  = st_r.offset;
    assign phase_o         = st_r.phase;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_turn_off;
        $fell(st_r.gate) ##0 (st_r.phase == QRS_RING);
    endsequence

    sequence s_step_up;
        eval_end && !st_r.seen_low && !st_r.seen_high && !fb_low_s && !fb_high_s && !fb_reset_s &&
            (st_r.vsel != `QRS_VSEL_MAX);
    endsequence

    a_vsel_range: assert property ((st_r.vsel >= `QRS_VSEL_MIN) && (st_r.vsel <= `QRS_VSEL_MAX))
        else $error("valley select out of range");
    a_vsel_startup: assert property ($rose(reset_n_i) |-> st_r.vsel == `QRS_VSEL_MIN)
        else $error("valley select not 1 after start-up");
    a_vsel_force: assert property (fb_reset_s |=> st_r.vsel == `QRS_VSEL_MIN)
        else $error("reset threshold did not force valley select");
    a_vsel_step_up: assert property (s_step_up |=> st_r.vsel == $past(st_r.vsel) + 3'h1)
        else $error("valley select did not step up");
    a_vcnt_clear: assert property ($rose(st_r.gate) |-> st_r.vcnt == `QRS_VCNT_MIN)
        else $error("valley count not cleared at turn-on");
    a_vcnt_count: assert property ((st_r.phase == QRS_RING) && zc_fall && !ovp_s &&
                                   (st_r.vcnt != `QRS_VCNT_MAX)
                                   |=> st_r.vcnt == $past(st_r.vcnt) + 3'h1)
        else $error("zero crossing not counted");
    a_ring_length: assert property (s_turn_off |->
                                    st_r.ring_cnt == ($past(ringsel_s) ? RING_SHORT : RING_LONG))
        else $error("wrong ringing suppression length");
    a_ring_hold: assert property (s_turn_off |-> !st_r.gate [*8])
        else $error("gate rose inside ringing suppression");
    a_valley_on: assert property ((st_r.phase == QRS_WAIT) && (st_r.vcnt >= st_r.vsel)
                                  |=> st_r.gate || st_r.latched)
        else $error("no turn-on at selected valley");
    a_offmax_on: assert property ((st_r.phase == QRS_WAIT) && (st_r.phase_cnt >= OFFMAX_LST)
                                  |=> st_r.gate || st_r.latched)
        else $error("maximum off-time not enforced");
    a_leb_min: assert property (s_turn_off |-> $past(st_r.phase_cnt) >= LEB_CYC)
        else $error("gate shorter than blanking time");
    a_limit_off: assert property ((st_r.phase == QRS_ON) && !blank && (cs_lim_s || cs_fb_s)
                                  |=> !st_r.gate)
        else $error("current trip did not turn off");
    a_onmax_off: assert property (st_r.gate && (st_r.phase_cnt == ONMAX_LAST) |=> !st_r.gate)
        else $error("maximum on-time exceeded");
    a_latch_hold: assert property (st_r.latched |=> st_r.latched && !st_r.gate)
        else $error("latched-off state left");
    a_thr_follow: assert property (st_r.thr_sel == $past(line_s))
        else $error("threshold select not following line");
    a_fold_load: assert property ((st_r.phase == QRS_ON) && fold_s
                                  |=> st_r.offset == fold_lut($past(foldback_code_i)))
        else $error("foldback offset not loaded");

endmodule

/* test/qrs_far_side.sv */
`timescale 1ns/10ps

// ************************************************************
// Far side: winding, shunt and power switch
// ************************************************************
module qrs_far_side (
    input  wire logic        clk_i,
    input  wire logic        gate_i,
    input  wire logic [15:0] on_len_i,
    input  wire logic [2:0]  valleys_i,
    input  wire logic        lim_i,
    output logic             cs_fb_o,
    output logic             cs_lim_o,
    output logic             zc_o
);
    int   cnt = 0;
    logic g_d = 1'b0;

    // Off the sampling edge so the comparators never race the gate
    always @(negedge clk_i) begin
        cnt <= (gate_i === g_d) ? cnt + 1 : 0;
        g_d <= gate_i;
        // Shunt ramp crosses after on_len cycles; one of two comparators
        cs_fb_o <= (gate_i === 1'b1) && !lim_i && (cnt >= int'(on_len_i));
        cs_lim_o <= (gate_i === 1'b1) && lim_i && (cnt >= int'(on_len_i));
        // Damped ringing: valleys_i falls through 100mV, then settles low
        zc_o <= (gate_i !== 1'b1) && (cnt < 8 * int'(valleys_i)) && (cnt % 8 < 4);
    end
endmodule

/* test/quasi_resonant_switch_timing_tb_top.sv */
`timescale 1ns/10ps

module quasi_resonant_switch_timing_tb_top;
    import qrs_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic lo, hi, rs, line, ovp, rsel, sh, fold, lim;
    logic [3:0] code;
    logic [15:0] on_len;
    logic [2:0] valleys;
    logic cs_fb, cs_lim, zc, gate, latch, thr;
    logic [2:0] vsel, vcnt;
    logic [7:0] ofs;
    qrs_phase_t phase;
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    int seed, th, tl, ol, n, lb;
    logic [7:0] tbl [16] = '{8'h00, 8'h01, 8'h03, 8'h06, 8'h0A, 8'h0F, 8'h15, 8'h1C,
                             8'h24, 8'h2D, 8'h37, 8'h42, 8'h4E, 8'h5B, 8'h69, 8'h78};

    always #25 clk = ~clk;

    qrs_core #(.EVAL_CYCLES(64)) u_qrs_core (
        .clk_i(clk), .reset_n_i(rst_n), .fb_above_low_i(lo), .fb_above_high_i(hi),
        .fb_above_reset_i(rs), .line_high_i(line), .zc_above_100mv_i(zc),
        .zc_above_ovp_i(ovp), .zc_above_ringsel_i(rsel), .cs_above_fb_i(cs_fb),
        .cs_above_limit_i(cs_lim), .cs_above_short_i(sh), .foldback_over_i(fold),
        .foldback_code_i(code), .gate_output_a_o(gate), .latch_off_o(latch),
        .thr_line_high_o(thr), .valley_select_o(vsel), .valley_count_o(vcnt),
        .limit_offset_o(ofs), .phase_o(phase));

    qrs_far_side u_qrs_far_side (
        .clk_i(clk), .gate_i(gate), .on_len_i(on_len), .valleys_i(valleys),
        .lim_i(lim), .cs_fb_o(cs_fb), .cs_lim_o(cs_lim), .zc_o(zc));

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic close_out();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Range compare; an unknown value never lands inside the range
    task automatic chk(input string nm, input int l, input int h, input logic [15:0] g);
        compares++;
        if (((g >= l) && (g <= h)) !== 1'b1) begin
            fails++;
            $display("mismatch %s expected %0d..%0d seen %0h", nm, l, h, g);
        end
    endtask

    // Expected on-time: trip seen after two sync stages and one register; blanking floor, on-time ceiling
    function automatic int exp_on(input int o);
        return (o < 2) ? 6 : (o > 496) ? 500 : o + 4;
    endfunction

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            close_out();
        end
    end

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
    endtask

    task automatic wait_gate(input logic v);
        n = 0;
        while (gate !== v && n < 3000) begin
            @(negedge clk);
            n++;
        end
    endtask

    // One switching cycle: on-time and following off-time in clocks
    task automatic pulse(input int o, input int v, input logic lm, input logic rr);
        on_len = 16'(o);
        valleys = 3'(v);
        lim = lm;
        rsel = rr;
        wait_gate(1'b0);
        wait_gate(1'b1);
        th = 0;
        while (gate === 1'b1 && th < 3000) begin
            @(negedge clk);
            th++;
        end
        tl = 0;
        while (gate !== 1'b1 && tl < 3000) begin
            @(negedge clk);
            tl++;
        end
    endtask

    // Wait for the valley select to step to k, return clocks waited
    task automatic step_to(input int k);
        n = 0;
        while (vsel !== 3'(k) && n < 200) begin
            @(negedge clk);
            n++;
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        seed = 94885;
        {hi, rs, line, ovp, rsel, sh, fold, lim} = '0;
        lo = 1'b1;
        code = 4'h0;
        on_len = 16'h0000;
        valleys = 3'h1;
        @(negedge clk);
        do_reset();
        chk("vsel_rst", 1, 1, vsel);
        chk("vcnt_rst", 0, 0, vcnt);
        chk("gate_rst", 0, 0, gate);
        chk("phase_rst", QRS_RING, QRS_RING, phase);
        // Turn-off sources, blanking floor and on-time ceiling
        for (int i = 0; i < 8; i++) begin
            ol = (i == 0) ? 0 : (i == 1) ? 1000 : 10 + ($unsigned($random(seed)) % 300);
            // Limit comparator forced in two passes so both trip paths are met
            pulse(ol, 1, (i == 2 || i == 3) ? 1'b1 : (i < 2) ? 1'b0 : 1'($random(seed)), i % 2);
            lb = exp_on(ol);
            chk("on_time", lb, lb, th);
            chk("off_time", (i % 2) ? 51 : 401, (i % 2) ? 54 : 404, tl);
            chk("vcnt_clear", 0, 0, vcnt);
        end
        // Feedback never above low: one step up per period, stop at 7
        lo = 1'b0;
        step_to(2);
        for (int k = 3; k <= 7; k++) begin
            step_to(k);
            chk("vsel_up", k, k, vsel);
            chk("eval_period", 64, 64, n);
        end
        repeat (70) @(negedge clk);
        chk("vsel_top", 7, 7, vsel);
        pulse(60, 7, 1'b0, 1'b0);
        chk("off_valley7", 401, 404, tl);
        pulse(60, 6, 1'b0, 1'b0);
        chk("off_max", 900, 902, tl);
        // Feedback above high: step down to 1 and stay
        lo = 1'b1;
        hi = 1'b1;
        for (int k = 6; k >= 1; k--) begin
            step_to(k);
            chk("vsel_dn", k, k, vsel);
        end
        repeat (70) @(negedge clk);
        chk("vsel_floor", 1, 1, vsel);
        // Reset threshold forces the select straight back to 1
        hi = 1'b0;
        lo = 1'b0;
        step_to(3);
        rs = 1'b1;
        repeat (4) @(negedge clk);
        chk("vsel_force", 1, 1, vsel);
        rs = 1'b0;
        lo = 1'b1;
        // Foldback table for every code, line select alongside
        on_len = 16'd1000;
        wait_gate(1'b0);
        wait_gate(1'b1);
        fold = 1'b1;
        for (int c = 0; c < 16; c++) begin
            code = 4'(c);
            line = $random(seed) & 1;
            repeat (5) @(negedge clk);
            chk("limit_offset", tbl[c], tbl[c], ofs);
            chk("thr_line", line, line, thr);
        end
        fold = 1'b0;
        // Overvoltage while off: short burst ignored, long one latches
        on_len = 16'd30;
        valleys = 3'h0;
        wait_gate(1'b1);
        wait_gate(1'b0);
        ovp = 1'b1;
        repeat (10) @(negedge clk);
        ovp = 1'b0;
        repeat (5) @(negedge clk);
        chk("ovp_short", 0, 0, latch);
        ovp = 1'b1;
        repeat (26) @(negedge clk);
        chk("ovp_latch", 1, 1, latch);
        chk("ovp_gate", 0, 0, gate);
        ovp = 1'b0;
        do_reset();
        chk("latch_rst", 0, 0, latch);
        // Short winding: spike filtered, sustained trip latches
        on_len = 16'd1000;
        wait_gate(1'b1);
        sh = 1'b1;
        repeat (2) @(negedge clk);
        sh = 1'b0;
        repeat (5) @(negedge clk);
        chk("sw_spike", 0, 0, latch);
        sh = 1'b1;
        repeat (10) @(negedge clk);
        chk("sw_latch", 1, 1, latch);
        chk("sw_gate", 0, 0, gate);
        sh = 1'b0;
        close_out();
    end
endmodule
